// File: logic/uart_aux_modes.sv
// Auxiliary UART modes: multidrop, infrared, sleep and power-save, wake interrupt, loopback.
//
// Operation
// - Normal multidrop when select set, detect off.
// - Disabled receiver drops data, keeps address bytes.
// - Enabled receiver takes data; addresses still flagged.
// - Auto address when select and detect set.
// - Auto mode discards data while receiver disabled.
// - Matching address enables receiver, pushes with parity.
// - Non-matching address disables receiver, byte dropped.
// - Slow infrared: 3/16-bit pulse per zero.
// - Fast infrared: quarter-bit pulse per zero.
// - Infrared enable bit switches encoder and decoder.
// - Infrared receive idles low; pulse gives zero.
// - Sleep only when all idle conditions hold.
// - Oscillator output stops while asleep.
// - Wake on start bit, write or modem change.
// - Return to sleep after interrupts serviced.
// - Auto sleep persists until enable cleared.
// - Power-save isolates bus; wakes on start bit or modem change, not write.
// - Power-save ends on sleep disable or pin low.
// - Wake interrupt gated by enable, off after reset.
// - Loopback routes transmit shifter to receiver.
// - Loopback holds pins, ignores modem inputs.
// - Address match compares programmed word length only.
module uart_aux_modes
   import uart_aux_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
) (
   // ****************************************
   // Clock, reset and enable
   // ****************************************
   input  wire logic       ref_clk_in,
   input  wire logic       rst_in,
   input  wire logic       clk_en_in,
   // Configuration bits.
   input  wire logic       multidrop_sel_in,      // Multidrop select.
   input  wire logic       enhanced_unlock_in,    // Enhanced unlock.
   input  wire logic       special_detect_in,     // Special detect.
   input  wire logic [7:0] second_stop_char_in,   // Slave address.
   input  wire logic [1:0] word_len_in,           // Word length, 0 is five bits.
   input  wire logic       rx_enable_sw_in,       // Pulse: enable receiver.
   input  wire logic       rx_disable_sw_in,      // Pulse: disable receiver.
   input  wire logic       ir_enable_in,          // Infrared enable.
   input  wire logic       ir_fast_in,            // Infrared speed bit.
   input  wire logic       loopback_in,           // Loopback bit.
   input  wire logic       sleep_enable_in,       // Sleep enable.
   input  wire logic       wake_irq_enable_in,    // Wake interrupt enable.
   input  wire logic       power_save_input,      // Power-save pin.
   // Status from the core UART.
   input  wire logic       irq_pending_in,        // Any interrupt pending.
   input  wire logic [3:0] modem_delta_in,        // Modem change bits.
   input  wire logic       divisor_nonzero_in,    // Divisor nonzero.
   input  wire logic       tx_fifo_empty_in,      // Transmit FIFO empty.
   input  wire logic       irq_serviced_in,       // Interrupt serviced.
   // Receive path from the core deserialiser.
   input  wire logic       rx_byte_valid_in,      // Pulse: byte received.
   input  wire logic [7:0] rx_byte_in,            // Received character.
   input  wire logic       rx_parity_in,          // Received parity bit.
   // Transmit side.
   input  wire logic       tx_shift_in,           // Transmit shifter output.
   input  wire logic       tx_write_in,           // Transmitter write.
   input  wire logic       sample_tick_in,        // Sixteen-times bit tick.
   input  wire logic       bit_start_in,          // Bit start tick.
   // Bus-side isolation.
   input  wire logic       bus_active_in,         // Bus activity.
   // Serial and modem pins.
   input  wire logic       rx_pin_in,             // Receive pin.
   input  wire logic [3:0] modem_pins_in,         // Modem inputs, low active.
   input  wire logic       rts_core_in,           // Request-to-send from the core.
   input  wire logic       dtr_core_in,           // Terminal-ready from the core.
   // ****************************************
   // Outputs
   // ****************************************
   output      logic       rx_line_out,           // Serial input to the receiver.
   output      logic [3:0] modem_core_out,        // Modem inputs seen by the core.
   output      logic       tx_pin_out,            // Transmit pin.
   output      logic       rts_pin_out,           // Request-to-send pin.
   output      logic       dtr_pin_out,           // Terminal-ready pin.
   output      logic       rx_enabled_out,        // Receiver enable state.
   output      logic       line_status_irq_out,   // Pulse on address byte; in auto mode only on a matching address.
   output      logic       special_char_out,      // Pulse on character match.
   output      logic       osc_run_out,           // Oscillator running.
   output      logic       bus_isolate_out,       // Bus inputs isolated.
   output      logic       asleep_out,            // Device asleep.
   output      logic       wake_irq_out,          // Wake interrupt level.
   // Receive buffer toward the host side.
   output      logic       rx_valid_out,
   input  wire logic       rx_ready_in,
   output      logic [8:0] rx_data_out,           // Bit 8 is the parity-error flag.
   output      logic       rx_overrun_out         // Pulse: byte lost.
);

   // ****************************************
   // State record
   // ****************************************
   typedef struct packed {
      logic          rx_en;       // Receiver enable.
      pwr_state_type pwr;         // Power state.
      logic          wake_irq;    // Sticky wake interrupt.
      logic          rx_prev;     // Previous receive line level.
      logic [3:0]    modem_prev;  // Previous modem inputs.
      logic [4:0]    ir_cnt;      // Infrared pulse tick counter.
      logic          ir_pulse;    // Infrared transmit pulse.
      logic          lsr_irq;     // Line-status pulse.
      logic          spc;         // Special character pulse.
      logic          ovr;         // Overrun pulse.
      logic [8:0]    push_data;   // Byte waiting to enter the buffer.
      logic          push;        // Push request.
   } aux_state_type;

   aux_state_type s_q;            // Registered state.
   aux_state_type s_d;            // Next state.
   logic          fifo_in_ready;  // Buffer can accept.
   logic          fifo_empty;     // Buffer holds nothing.
   logic          line_in;        // Selected serial input.
   logic [7:0]    len_mask;       // Compare mask from word length.
   logic          addr_match;     // Address equals slave character.
   logic          is_addr;        // Parity one marks an address byte.
   logic          md_on;          // Multidrop active.
   logic          auto_addr;      // Automatic address detection active.
   logic          rx_idle;        // Receive line idle.
   logic          wake_event;     // Any wake cause.
   logic [4:0]    ir_width;       // Pulse width for chosen infrared speed.

   // ****************************************
   // Receive buffer instance
   // ****************************************
   aux_fifo #(.WIDTH(RX_WORD_W), .DEPTH(DEPTH)) u_rx_fifo (
      .ref_clk_in    (ref_clk_in),
      .rst_in        (rst_in),
      .clk_en_in     (clk_en_in),
      .in_valid_in   (s_q.push),
      .in_ready_out  (fifo_in_ready),
      .in_data_in    (s_q.push_data),
      .out_valid_out (rx_valid_out),
      .out_ready_in  (rx_ready_in),
      .out_data_out  (rx_data_out)
   );
   assign fifo_empty = !rx_valid_out && !s_q.push;

   // Loopback, infrared or plain line into the receiver.
   always_comb begin
      if (loopback_in) begin
         line_in = tx_shift_in;
      end else if (ir_enable_in) begin
         line_in = !rx_pin_in;
      end else begin
         line_in = rx_pin_in;
      end
   end
   assign rx_line_out = line_in;

   // Modem inputs are masked inactive (high) in loopback.
   assign modem_core_out = loopback_in ? 4'hf : modem_pins_in;

   // Pins: mark on transmit, modem outputs released during loopback.
   assign tx_pin_out  = loopback_in ? 1'b1 : (ir_enable_in ? s_q.ir_pulse : tx_shift_in);
   assign rts_pin_out = loopback_in ? 1'b1 : rts_core_in;
   assign dtr_pin_out = loopback_in ? 1'b1 : dtr_core_in;

   // Compare only the programmed character bits.
   assign len_mask   = 8'hff >> (3'h3 - {1'b0, word_len_in});
   assign addr_match = ((rx_byte_in ^ second_stop_char_in) & len_mask) == 8'h00;
   assign is_addr    = rx_parity_in;
   assign md_on      = multidrop_sel_in && enhanced_unlock_in;
   assign auto_addr  = md_on && special_detect_in;
   assign ir_width   = (ir_fast_in && enhanced_unlock_in) ? IR_PULSE_FAST : IR_PULSE_SLOW;

   // Idle level depends on mode; loopback counts as idle.
   assign rx_idle = loopback_in || (ir_enable_in ? !rx_pin_in : rx_pin_in);

   // Writes cannot wake through isolation.
   assign wake_event = (s_q.rx_prev && !line_in)
                     || (modem_core_out != s_q.modem_prev)
                     || (tx_write_in && (s_q.pwr != PWR_SAVE));

   // Outputs from registered state.
   assign rx_enabled_out      = s_q.rx_en;
   assign line_status_irq_out = s_q.lsr_irq;
   assign special_char_out    = s_q.spc;
   assign rx_overrun_out      = s_q.ovr;
   assign asleep_out          = (s_q.pwr != PWR_AWAKE);
   assign osc_run_out         = (s_q.pwr == PWR_AWAKE);
   assign bus_isolate_out     = (s_q.pwr == PWR_SAVE) && !bus_active_in;
   assign wake_irq_out        = s_q.wake_irq;

   // ****************************************
   // Next-state logic
   // ****************************************
   always_comb begin
      s_d            = s_q;
      s_d.lsr_irq    = 1'b0;
      s_d.spc        = 1'b0;
      s_d.ovr        = 1'b0;
      s_d.rx_prev    = line_in;
      s_d.modem_prev = modem_core_out;
      // A pending push waits for room in the buffer.
      if (s_q.push && fifo_in_ready) begin
         s_d.push = 1'b0;
      end

      // Software receiver control; hardware decisions below override it.
      if (rx_enable_sw_in) begin
         s_d.rx_en = 1'b1;
      end else if (rx_disable_sw_in) begin
         s_d.rx_en = 1'b0;
      end

      // Received byte filtering.
      if (rx_byte_valid_in) begin
         if (s_d.push && !fifo_in_ready) begin
            // Buffer blocked: this byte is lost.
            s_d.ovr = 1'b1;
         end else if (auto_addr) begin
            if (is_addr && addr_match) begin
               s_d.rx_en     = 1'b1;
               s_d.push      = 1'b1;
               s_d.push_data = {rx_parity_in, rx_byte_in};
               s_d.lsr_irq   = 1'b1;
            end else if (is_addr) begin
               s_d.rx_en = 1'b0;
            end else if (s_q.rx_en) begin
               s_d.push      = 1'b1;
               s_d.push_data = {1'b0, rx_byte_in};
            end
            // Data with receiver off is discarded here.
         end else if (md_on) begin
            if (is_addr) begin
               s_d.push      = 1'b1;
               s_d.push_data = {1'b1, rx_byte_in};
               s_d.lsr_irq   = 1'b1;
            end else if (s_q.rx_en) begin
               s_d.push      = 1'b1;
               s_d.push_data = {1'b0, rx_byte_in};
            end
         end else begin
            s_d.push      = 1'b1;
            s_d.push_data = {1'b0, rx_byte_in};
            s_d.spc       = special_detect_in && enhanced_unlock_in && addr_match;
         end
      end

      // Infrared encoder: pulse on each zero bit.
      if (bit_start_in && sample_tick_in) begin
         s_d.ir_cnt   = tx_shift_in ? 5'h00 : ir_width;
         s_d.ir_pulse = !tx_shift_in;
      end else if (sample_tick_in && s_q.ir_cnt != 5'h00) begin
         s_d.ir_cnt   = s_q.ir_cnt - 5'h01;
         s_d.ir_pulse = (s_q.ir_cnt != 5'h01);
      end

      // Power state machine.
      case (s_q.pwr)
         PWR_AWAKE: begin
            // All idle conditions.
            if (sleep_enable_in && !irq_pending_in && modem_delta_in == 4'h0 && rx_idle
                && divisor_nonzero_in && tx_fifo_empty_in && fifo_empty && !wake_event) begin
               s_d.pwr = power_save_input ? PWR_SAVE : PWR_SLEEP;
            end
         end
         PWR_SLEEP, PWR_SAVE: begin
            if (wake_event || !sleep_enable_in) begin
               s_d.pwr = PWR_AWAKE;
               if (wake_event && wake_irq_enable_in) begin
                  s_d.wake_irq = 1'b1;
               end
            end else if (s_q.pwr == PWR_SAVE && !power_save_input) begin
               s_d.pwr = PWR_SLEEP;
            end else if (s_q.pwr == PWR_SLEEP && power_save_input) begin
               s_d.pwr = PWR_SAVE;
            end
         end
         default: begin
            s_d.pwr = PWR_AWAKE;
         end
      endcase

      // Servicing clears the wake interrupt unless a new wake sets it again.
      if (irq_serviced_in && !(s_d.wake_irq && !s_q.wake_irq)) begin
         s_d.wake_irq = 1'b0;
      end
      if (!wake_irq_enable_in) begin
         s_d.wake_irq = 1'b0;
      end
   end

   // ****************************************
   // State register
   // ****************************************
   // Synchronous reset; the clock enable freezes all state.
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         s_q          <= '0;
         s_q.rx_en    <= RST_RX_ENABLE;
         s_q.wake_irq <= RST_WAKE_IRQ;
         s_q.pwr      <= PWR_AWAKE;
         s_q.rx_prev  <= 1'b1;
      end else if (clk_en_in) begin
         s_q <= s_d;
      end
   end
endmodule

// File: logic/uart_aux_pkg.sv
// Package with constants and types shared by the auxiliary-mode UART logic.
package uart_aux_pkg;

   // ****************************************
   // Timing and encoding constants
   // ****************************************
   localparam logic [4:0]  IR_PULSE_SLOW   = 5'h03;     // Pulse ticks, 3/16 bit.
   localparam logic [4:0]  IR_PULSE_FAST   = 5'h04;     // Pulse ticks, 1/4 bit.
   localparam int          FIFO_DEPTH      = 8;         // Receive buffer depth.
   localparam int          RX_WORD_W       = 9;         // Byte plus parity-error flag.

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic        RST_RX_ENABLE   = 1'b0;      // Receiver starts disabled.
   localparam logic        RST_WAKE_IRQ    = 1'b0;      // Wake interrupt latched off.

   // ****************************************
   // Power state enumeration
   // ****************************************
   typedef enum logic [1:0] {
      PWR_AWAKE,
      PWR_SLEEP,
      PWR_SAVE
   } pwr_state_type;

endpackage

// File: logic/aux_fifo.sv
// Synchronous flip-flop FIFO with valid and ready on both sides.
module aux_fifo
   import uart_aux_pkg::*;
#(
   parameter int WIDTH = RX_WORD_W,
   parameter int DEPTH = FIFO_DEPTH
) (
   // Clock, reset and enable.
   input  wire logic             ref_clk_in,
   input  wire logic             rst_in,
   input  wire logic             clk_en_in,
   // Filling side.
   input  wire logic             in_valid_in,
   output      logic             in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   // Draining side.
   output      logic             out_valid_out,
   input  wire logic             out_ready_in,
   output      logic [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);

   // All state kept in one packed record.
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr;
      logic [AW-1:0]               rd;
      logic [AW:0]                 cnt;
   } fifo_state_type;

   fifo_state_type s_q;   // Registered state.
   fifo_state_type s_d;   // Next state.
   logic           push;  // Accepted write.
   logic           pop;   // Accepted read.

   // Handshakes are honest: full refuses, empty shows no data.
   assign in_ready_out  = (s_q.cnt != DEPTH[AW:0]);
   assign out_valid_out = (s_q.cnt != '0);
   assign out_data_out  = s_q.mem[s_q.rd];
   assign push          = in_valid_in && in_ready_out;
   assign pop           = out_valid_out && out_ready_in;

   // Next state.
   always_comb begin
      s_d = s_q;
      if (push) begin
         s_d.mem[s_q.wr] = in_data_in;
         s_d.wr          = (s_q.wr == AW'(DEPTH - 1)) ? '0 : s_q.wr + 1'b1;
      end
      if (pop) begin
         s_d.rd = (s_q.rd == AW'(DEPTH - 1)) ? '0 : s_q.rd + 1'b1;
      end
      s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   // State register; clock enable freezes everything.
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         s_q <= '0;
      end else if (clk_en_in) begin
         s_q <= s_d;
      end
   end
endmodule

// File: testbench/line_node.sv
// Remote serial node or infrared transceiver on the line pins.
module line_node (
   // Clock of the bench.
   input  wire logic       ref_clk_in,
   // Requests from the bench.
   input  wire logic       ir_mode_in,      // Infrared transceiver fitted.
   input  wire logic       start_req_in,    // Pulse: send one start bit.
   input  wire logic [3:0] modem_level_in,  // Levels for the modem lines.
   // Line pins toward the device.
   output      logic       rx_pin_out,
   output      logic [3:0] modem_pins_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] bit_left_q = 5'h00;          // Clocks left of the start bit.
   // A start bit lasts sixteen clocks.
   always_ff @(posedge ref_clk_in) begin
      if (start_req_in) begin
         bit_left_q <= 5'h10;
      end else if (bit_left_q != 5'h00) begin
         bit_left_q <= bit_left_q - 5'h01;
      end
   end
   // Wire idles high; infrared idles low, light for a zero.
   assign rx_pin_out = ir_mode_in ? (bit_left_q != 5'h00) : (bit_left_q == 5'h00);
   assign modem_pins_out = modem_level_in;
endmodule

// File: testbench/uart_aux_modes_assertions.sv
// Checker of the auxiliary UART modes, bound to the block's ports.
module uart_aux_modes_checker (
   // Clock and reset.
   input wire logic       ref_clk_in, rst_in,
   // Inputs that steer the modes.
   input wire logic       loopback_in, tx_shift_in, ir_enable_in, rx_pin_in,
   input wire logic       sleep_enable_in, irq_pending_in, wake_irq_enable_in,
   input wire logic       multidrop_sel_in, enhanced_unlock_in, special_detect_in,
   input wire logic       rx_byte_valid_in, rx_parity_in,
   input wire logic [7:0] rx_byte_in, second_stop_char_in,
   input wire logic [1:0] word_len_in,
   // Outputs under watch.
   input wire logic       tx_pin_out, rx_line_out, asleep_out, osc_run_out,
   input wire logic       wake_irq_out, rx_enabled_out, line_status_irq_out,
   input wire logic [3:0] modem_core_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk_in);
   endclocking
   default disable iff (rst_in);
   // Address compare over the word length.
   wire logic addr_hit = ((rx_byte_in ^ second_stop_char_in) & (8'hff >> (2'h3 - word_len_in))) == 8'h00;
   // Address byte in automatic detection.
   sequence auto_addr_s;
      rx_byte_valid_in && rx_parity_in && multidrop_sel_in && enhanced_unlock_in && special_detect_in;
   endsequence
   // Start edge on the wire while asleep.
   sequence start_edge_s;
      asleep_out && !ir_enable_in && !loopback_in && $fell(rx_pin_in);
   endsequence
   loop_pins_a:
      assert property (loopback_in |-> tx_pin_out && modem_core_out == 4'hf) else $error("loop pins");
   loop_route_a:
      assert property (loopback_in |-> rx_line_out == tx_shift_in) else $error("loop route");
   ir_decode_a:
      assert property (ir_enable_in && !loopback_in |-> rx_line_out == !rx_pin_in) else $error("ir decode");
   osc_stop_a:
      assert property (asleep_out |-> !osc_run_out) else $error("osc runs");
   pending_awake_a:
      assert property (!asleep_out && irq_pending_in |=> !asleep_out) else $error("slept pending");
   sleep_off_a:
      assert property (!sleep_enable_in |=> !asleep_out) else $error("slept disabled");
   wake_gate_a:
      assert property ($past(wake_irq_enable_in) == 1'b0 |-> !wake_irq_out) else $error("wake ungated");
   start_wake_a:
      assert property (start_edge_s |=> !asleep_out) else $error("no start wake");
   wake_irq_a:
      assert property (start_edge_s ##0 wake_irq_enable_in |=> wake_irq_out) else $error("no wake irq");
   addr_flag_a:
      assert property (rx_byte_valid_in && rx_parity_in && multidrop_sel_in && enhanced_unlock_in
         && !special_detect_in |=> line_status_irq_out) else $error("address unflagged");
   auto_hit_a:
      assert property (auto_addr_s ##0 addr_hit |=> rx_enabled_out && line_status_irq_out) else $error("match ignored");
   auto_miss_a:
      assert property (auto_addr_s ##0 !addr_hit |=> !rx_enabled_out) else $error("mismatch kept");
endmodule

bind uart_aux_modes uart_aux_modes_checker checker_i (.*);

// File: testbench/uart_aux_modes_bench.sv
// Self-checking bench of the auxiliary UART modes block.
module uart_aux_modes_bench import uart_aux_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   // Inputs, then push, flag, enable.
   typedef struct packed {
      logic md, det;
      logic [1:0] sw, wl;
      logic par;
      logic [7:0] b;
      logic push, line_status_register, en;
   } row_type;
   row_type rows [13] = '{
      '{1,0,0,3,0,8'h11,0,0,0}, '{1,0,0,3,1,8'h22,1,1,0},
      '{1,0,1,3,0,8'h33,1,0,1}, '{1,0,0,3,1,8'h44,1,1,1},
      '{1,1,2,3,0,8'h55,0,0,0}, '{1,1,0,3,1,8'h23,0,0,0},
      '{1,1,0,3,1,8'h5a,1,1,1}, '{1,1,0,3,0,8'h66,1,0,1},
      '{1,1,0,3,1,8'h5a,1,1,1}, '{1,1,0,3,1,8'h21,0,0,0},
      '{1,1,0,0,1,8'hfa,1,1,1}, '{1,1,0,0,1,8'h1b,0,0,0},
      '{0,1,0,3,0,8'h5a,1,1,0}};
   // Inputs.
   logic       clk_en_in = 1'b1, divisor_nonzero_in = 1'b1, tx_fifo_empty_in = 1'b1, rts_core_in = 1'b0;
   logic       dtr_core_in = 1'b0, ref_clk_in = 1'b0, rst_in = 1'b1, multidrop_sel_in = 1'b0;
   logic       enhanced_unlock_in = 1'b0, special_detect_in = 1'b0, rx_enable_sw_in = 1'b0, rx_disable_sw_in = 1'b0;
   logic       ir_enable_in = 1'b0, ir_fast_in = 1'b0, loopback_in = 1'b0, sleep_enable_in = 1'b0;
   logic       wake_irq_enable_in = 1'b0, power_save_input = 1'b0, irq_pending_in = 1'b0, irq_serviced_in = 1'b0;
   logic       rx_byte_valid_in = 1'b0, rx_parity_in = 1'b0, tx_shift_in = 1'b1, tx_write_in = 1'b0;
   logic       sample_tick_in = 1'b0, bit_start_in = 1'b0, bus_active_in = 1'b0, rx_ready_in = 1'b0;
   logic       start_req = 1'b0, lsr_seen = 1'b0, ovr_seen = 1'b0;
   logic [7:0] second_stop_char_in = 8'h5a, rx_byte_in = 8'h00;
   logic [1:0] word_len_in = 2'h3;
   logic [3:0] modem_delta_in = 4'h0, modem_level = 4'hf;
   wire logic  rx_pin_in;
   wire logic [3:0] modem_pins_in;
   // Outputs of the block.
   logic       rx_line_out, tx_pin_out, rts_pin_out, dtr_pin_out, rx_enabled_out, line_status_irq_out;
   logic       special_char_out, osc_run_out, bus_isolate_out, asleep_out, wake_irq_out, rx_valid_out;
   logic       rx_overrun_out;
   logic [3:0] modem_core_out;
   logic [8:0] rx_data_out, ir_want;
   int         miscompares = 0, comparisons = 0, hi;
   uart_aux_modes #(.DEPTH(FIFO_DEPTH)) dut (.*);
   line_node node (.ref_clk_in(ref_clk_in), .ir_mode_in(ir_enable_in), .start_req_in(start_req),
      .modem_level_in(modem_level), .rx_pin_out(rx_pin_in), .modem_pins_out(modem_pins_in));
   // 40 MHz clock.
   initial begin
      forever #12.5 ref_clk_in = ~ref_clk_in;
   end
   // Sticky pulses; a new byte clears the flag copy.
   always @(posedge ref_clk_in) begin
      lsr_seen <= rx_byte_valid_in ? 1'b0 : lsr_seen | line_status_irq_out | special_char_out;
      ovr_seen <= ovr_seen | rx_overrun_out;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk_in);
   endtask
   task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic give_verdict;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Run is under 2000 cycles.
   initial begin
      cyc(8000);
      miscompares++;
      $display("Error watchdog expected finish seen timeout");
      give_verdict();
   end
   initial begin
      row_type r;
      cyc(4);
      rst_in <= 1'b0;
      @(negedge ref_clk_in);
      check("reset state", 9'h004, 9'({rx_enabled_out, wake_irq_out, osc_run_out, rx_valid_out, asleep_out}));
      foreach (rows[i]) begin
         r = rows[i];
         cyc(1);
         enhanced_unlock_in <= 1'b1;
         {multidrop_sel_in, special_detect_in, word_len_in} <= {r.md, r.det, r.wl};
         {rx_disable_sw_in, rx_enable_sw_in} <= r.sw;
         cyc(1);
         {rx_disable_sw_in, rx_enable_sw_in} <= 2'h0;
         {rx_byte_valid_in, rx_parity_in, rx_byte_in} <= {1'b1, r.par, r.b};
         cyc(1);
         rx_byte_valid_in <= 1'b0;
         cyc(3);
         @(negedge ref_clk_in);
         check("flags", 9'({r.push, r.line_status_register, r.en}), 9'({rx_valid_out, lsr_seen, rx_enabled_out}));
         if (r.push) begin
            check("data", {r.par, r.b}, rx_data_out);
            cyc(1);
            rx_ready_in <= 1'b1;
            cyc(1);
            rx_ready_in <= 1'b0;
         end
      end
      // Ten bytes, no reader: eight stored, one waits, one lost.
      cyc(1);
      {special_detect_in, word_len_in, rx_enable_sw_in} <= {1'b0, 2'h3, 1'b1};
      cyc(1);
      {rx_enable_sw_in, rx_byte_valid_in, rx_parity_in} <= 3'h2;
      for (int i = 0; i < 10; i++) begin
         rx_byte_in <= 8'(i);
         cyc(1);
      end
      rx_byte_valid_in <= 1'b0;
      cyc(3);
      rx_ready_in <= 1'b1;
      for (int i = 0; i < 9; i++) begin
         @(negedge ref_clk_in);
         check("drain word", {1'b0, 8'(i)}, rx_valid_out ? rx_data_out : 9'h1ff);
         cyc(1);
      end
      rx_ready_in <= 1'b0;
      @(negedge ref_clk_in);
      check("overrun then empty", 9'h002, 9'({ovr_seen, rx_valid_out}));
      cyc(1);
      {sleep_enable_in, wake_irq_enable_in, modem_delta_in, irq_pending_in} <= {2'h3, 4'h1, 1'b1};
      cyc(4);
      @(negedge ref_clk_in);
      check("busy keeps awake", 9'h000, 9'(asleep_out));
      cyc(1);
      {modem_delta_in, irq_pending_in} <= 5'h00;
      cyc(3);
      @(negedge ref_clk_in);
      check("asleep clock off", 9'h002, 9'({asleep_out, osc_run_out}));
      cyc(1);
      start_req <= 1'b1;
      cyc(1);
      start_req <= 1'b0;
      cyc(1);
      @(negedge ref_clk_in);
      check("start wakes", 9'h001, 9'({asleep_out, wake_irq_out}));
      cyc(1);
      irq_serviced_in <= 1'b1;
      cyc(1);
      irq_serviced_in <= 1'b0;
      cyc(24);
      @(negedge ref_clk_in);
      check("asleep again", 9'h002, 9'({asleep_out, wake_irq_out}));
      cyc(1);
      tx_write_in <= 1'b1;
      cyc(1);
      tx_write_in <= 1'b0;
      @(negedge ref_clk_in);
      check("write wakes", 9'h000, 9'(asleep_out));
      cyc(1);
      power_save_input <= 1'b1;
      cyc(4);
      tx_write_in <= 1'b1;
      cyc(1);
      tx_write_in <= 1'b0;
      @(negedge ref_clk_in);
      check("save ignores write", 9'h003, 9'({asleep_out, bus_isolate_out}));
      cyc(1);
      {bus_active_in, modem_level} <= {1'b1, 4'he};
      cyc(1);
      @(negedge ref_clk_in);
      check("modem change wakes", 9'h000, 9'({asleep_out, bus_isolate_out}));
      cyc(4);
      {power_save_input, bus_active_in} <= 2'h0;
      cyc(3);
      @(negedge ref_clk_in);
      check("save left", 9'h002, 9'({asleep_out, bus_isolate_out}));
      cyc(1);
      {sleep_enable_in, wake_irq_enable_in} <= 2'h0;
      cyc(2);
      @(negedge ref_clk_in);
      check("sleep and irq off", 9'h000, 9'({asleep_out, wake_irq_out}));
      cyc(1);
      {ir_enable_in, sample_tick_in} <= 2'h3;
      for (int m = 0; m < 3; m++) begin
         {ir_fast_in, tx_shift_in, bit_start_in} <= {m == 1, m == 2, 1'b1};
         cyc(1);
         bit_start_in <= 1'b0;
         hi = 0;
         repeat (16) begin
            @(negedge ref_clk_in);
            hi += int'(tx_pin_out === 1'b1);
            cyc(1);
         end
         ir_want = (m == 0) ? 9'(IR_PULSE_SLOW) : (m == 1) ? 9'(IR_PULSE_FAST) : 9'h000;
         check("ir pulse width", ir_want, 9'(hi));
      end
      check("ir idle line", 9'h001, 9'(rx_line_out));
      {ir_enable_in, loopback_in} <= 2'h1;
      for (int v = 0; v < 2; v++) begin
         tx_shift_in <= v[0];
         cyc(1);
         @(negedge ref_clk_in);
         check("loopback", {5'hf, 3'h7, v[0]}, 9'({modem_core_out, tx_pin_out, rts_pin_out, dtr_pin_out, rx_line_out}));
         cyc(1);
      end
      give_verdict();
   end
endmodule
